// >>> hdsm_pkg.sv
// Constants, field layout and codes of the hydraulic drive signal mapper
// Operation
// [R01] Pole-changing motor uses only the four contactors, no drive control outputs.
// [R02] Hydraulic: contactor one up, two down, three fast, four per pump model.
// [R03] Star-delta pump model: fourth contactor switches the pump into delta.
// [R04] With ramp gating on, no valve output before soft-starter ramp-up done.
// [R05] Readiness input gates valves only while its usage option is on.
// [R06] Drive holds readiness high while ready and low when not ready.
// [R07] Simple 3/4-valve drives get a slow-up valve with afterrun delay.
// [R08] Pump afterrun applies only to upward travel, never downward.
// [R09] Valve and pump afterrun are in milliseconds; zero means off, reset zero.
// [R10] Profile one: creep/relevel 7 or 8 alone; otherwise 7+5 or 8+6.
// [R11] Profile one adds 1 slow, 2 medium, 3 intermediate, 4 inspection/emergency.
// [R12] Profile one takes safety-valve feedback on the run-state input.
// [R13] Profile two: creep/relevel 7 or 8 alone; slow adds output 3.
// [R14] Profile two: medium 7+5 or 8+6; inspection/emergency adds output 4.
// [R15] Profile two accepts run, ready and pump-enable feedback on own inputs.
// [R16] Pump-enable feedback acts only while its usage option is on.
// [R17] Profile three: creep/relevel 7 or 8; speed one, inspection, emergency add 3.
// [R18] Exactly one profile selected; outputs not named for speed stay low.
package hdsm_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int AFTERRUN_UNIT_NS = 1000000;
  localparam int CYC_PER_MS = (AFTERRUN_UNIT_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  // ****************************************
  // Register byte addresses and reset values
  // ****************************************
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] VALVE_AR_ADDR = 8'h04;
  localparam logic [7:0] PUMP_AR_ADDR = 8'h08;
  localparam logic [7:0] CMD_ADDR = 8'h0c;
  localparam logic [7:0] STATUS_ADDR = 8'h10;
  localparam int CTRL_W = 9;
  localparam int CMD_W = 7;
  localparam logic [8:0] CTRL_RESET = 9'h000;
  localparam logic [15:0] AFTERRUN_RESET = 16'h0000;
  localparam logic [6:0] CMD_RESET = 7'h00;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_HYD_BIT = 0;
  localparam int CTRL_PROF_LSB = 1;
  localparam int CTRL_AUX_LSB = 3;
  localparam int CTRL_RAMP_BIT = 5;
  localparam int CTRL_READY_BIT = 6;
  localparam int CTRL_PEN_BIT = 7;
  localparam int CTRL_SIMPLE_BIT = 8;
  localparam int CMD_UP_BIT = 0;
  localparam int CMD_DOWN_BIT = 1;
  localparam int CMD_SPEED_LSB = 4;
  localparam int STAT_OUT_LSB = 8;
  localparam int STAT_DC_LSB = 16;
  // ****************************************
  // Codes
  // ****************************************
  localparam logic [2:0] SPD_CREEP = 3'h0;
  localparam logic [2:0] SPD_SLOW = 3'h1;
  localparam logic [2:0] SPD_MEDIUM = 3'h2;
  localparam logic [2:0] SPD_INTERMEDIATE = 3'h3;
  localparam logic [2:0] SPD_RATED = 3'h4;
  localparam logic [2:0] SPD_INSPECTION = 3'h5;
  localparam logic [2:0] SPD_EMERGENCY = 3'h6;
  localparam logic [2:0] SPD_RELEVEL = 3'h7;
  localparam logic [1:0] PROF_NONE = 2'h0;
  localparam logic [1:0] PROF_FIRST = 2'h1;
  localparam logic [1:0] PROF_SECOND = 2'h2;
  localparam logic [1:0] PROF_THIRD = 2'h3;
  localparam logic [1:0] AUX_SOFT_START = 2'h0;
  localparam logic [1:0] AUX_STAR_DELTA = 2'h1;
  localparam logic [1:0] AUX_INVERTER = 2'h2;
  localparam logic [1:0] AUX_UP_ONLY = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Drive control output n sits at bit n-1
  localparam logic [7:0] DC_OUT1 = 8'h01;
  localparam logic [7:0] DC_OUT2 = 8'h02;
  localparam logic [7:0] DC_OUT3 = 8'h04;
  localparam logic [7:0] DC_OUT4 = 8'h08;
  localparam logic [7:0] DC_OUT5 = 8'h10;
  localparam logic [7:0] DC_OUT6 = 8'h20;
  localparam logic [7:0] DC_OUT7 = 8'h40;
  localparam logic [7:0] DC_OUT8 = 8'h80;
endpackage

// >>> hdsm_afterrun_if.sv
// Link between the mapper and one afterrun timer
`timescale 1ns/1ps
interface hdsm_afterrun_if;
  logic demand;
  logic [15:0] delay_ms;
  logic hold;
  modport owner(output demand, output delay_ms, input hold);
  modport timer(input demand, input delay_ms, output hold);
endinterface

// >>> hdsm_afterrun.sv
// Millisecond afterrun timer: holds an output after its demand falls
`timescale 1ns/1ps
module hdsm_afterrun
  import hdsm_pkg::*;
#(
  parameter int CYC_PER_MS_P = CYC_PER_MS
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Owner side
  hdsm_afterrun_if.timer tmr
);
  logic busy;
  logic next_busy;
  logic [15:0] ms_left;
  logic [15:0] next_ms_left;
  logic [15:0] cyc;
  logic [15:0] next_cyc;

  // ****************************************
  // Countdown
  // ****************************************
  always_comb begin
    next_busy = busy;
    next_ms_left = ms_left;
    next_cyc = cyc;
    if (tmr.demand) begin
      next_busy = 1'b1;
      next_ms_left = tmr.delay_ms; // [R09]
      next_cyc = 16'h0000;
    end else if (busy) begin
      if (ms_left == 16'h0000) begin
        next_busy = 1'b0; // [R09]
      end else if (cyc == 16'(CYC_PER_MS_P - 1)) begin
        next_cyc = 16'h0000;
        next_ms_left = ms_left - 16'h0001;
      end else begin
        next_cyc = cyc + 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      ms_left <= 16'h0000;
      cyc <= 16'h0000;
    end else begin
      busy <= next_busy;
      ms_left <= next_ms_left;
      cyc <= next_cyc;
    end
  end

  assign tmr.hold = busy;

  // Zero delay means off: hold ends one cycle after the demand
  property p_zero_delay_off;
    @(posedge aclk) disable iff (!aresetn)
      busy && !tmr.demand && ms_left == 16'h0000 |=> !busy;
  endproperty
  a_zero_delay_off: assert property (p_zero_delay_off) // [R09]
    else $error("afterrun hold outlived a zero delay");
endmodule

// >>> hdsm_mapper.sv
// Contactor and valve output mapper with AXI4-Lite registers
`timescale 1ns/1ps
module hdsm_mapper
  import hdsm_pkg::*;
#(
  parameter int CYC_PER_MS_P = CYC_PER_MS
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Feedback pins from soft starter, drive and valve card
  input wire logic ramp_done,
  input wire logic drive_ready,
  input wire logic safety_valve_feedback,
  input wire logic valve_ready_feedback,
  input wire logic pump_enable_request,
  // Contactors and valves
  output logic up_contactor,
  output logic down_contactor,
  output logic fast_contactor,
  output logic pump_aux_contactor,
  output logic slow_up_valve,
  output logic [7:0] drive_ctrl
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic ramp_s;
  logic ready_s;
  logic pen_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
    end else begin
      pin_meta <= {pump_enable_request, valve_ready_feedback,
        safety_valve_feedback, drive_ready, ramp_done};
      pin_sync <= pin_meta;
    end
  end

  assign ramp_s = pin_sync[0];
  assign ready_s = pin_sync[1];
  assign pen_s = pin_sync[4];

  // ****************************************
  // Register file and bus slave
  // ****************************************
  logic [CTRL_W-1:0] ctrl;
  logic [CTRL_W-1:0] next_ctrl;
  logic [15:0] valve_ar;
  logic [15:0] next_valve_ar;
  logic [15:0] pump_ar;
  logic [15:0] next_pump_ar;
  logic [CMD_W-1:0] cmd;
  logic [CMD_W-1:0] next_cmd;
  logic [7:0] aw_addr;
  logic [7:0] next_aw_addr;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0] w_strb;
  logic [3:0] next_w_strb;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [31:0] status_word;
  logic [31:0] old_word;
  logic [31:0] merged;
  logic valve_hold;
  logic pump_hold;
  logic allowed;

  // Bytes not strobed keep their old value
  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
    input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  assign status_word = {8'h00, drive_ctrl, 3'h0, slow_up_valve,
    pump_aux_contactor, fast_contactor, down_contactor, up_contactor,
    allowed, valve_hold, pump_hold, pin_sync};

  always_comb begin
    next_ctrl = ctrl;
    next_valve_ar = valve_ar;
    next_pump_ar = pump_ar;
    next_cmd = cmd;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_awready = awready;
    next_wready = wready;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_arready = arready;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    case (aw_addr)
      CTRL_ADDR: old_word = {23'h0, ctrl};
      VALVE_AR_ADDR: old_word = {16'h0000, valve_ar};
      PUMP_AR_ADDR: old_word = {16'h0000, pump_ar};
      CMD_ADDR: old_word = {25'h0, cmd};
      default: old_word = 32'h00000000;
    endcase
    merged = merge_bytes(old_word, w_data, w_strb);
    if (awvalid && awready) begin
      next_awready = 1'b0;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_wready = 1'b0;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    // Both halves held: commit once, then answer
    if (!awready && !wready && !bvalid) begin
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      case (aw_addr)
        CTRL_ADDR: next_ctrl = merged[CTRL_W-1:0]; // [R18]
        VALVE_AR_ADDR: next_valve_ar = merged[15:0]; // [R09]
        PUMP_AR_ADDR: next_pump_ar = merged[15:0]; // [R09]
        CMD_ADDR: next_cmd = merged[CMD_W-1:0];
        STATUS_ADDR: next_bresp = RESP_OKAY;
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
      next_awready = 1'b1;
      next_wready = 1'b1;
    end
    if (arvalid && arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      case (araddr)
        CTRL_ADDR: next_rdata = {23'h0, ctrl};
        VALVE_AR_ADDR: next_rdata = {16'h0000, valve_ar};
        PUMP_AR_ADDR: next_rdata = {16'h0000, pump_ar};
        CMD_ADDR: next_rdata = {25'h0, cmd};
        STATUS_ADDR: next_rdata = status_word; // [R12] [R15]
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
      valve_ar <= AFTERRUN_RESET;
      pump_ar <= AFTERRUN_RESET;
      cmd <= CMD_RESET;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else begin
      ctrl <= next_ctrl;
      valve_ar <= next_valve_ar;
      pump_ar <= next_pump_ar;
      cmd <= next_cmd;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // ****************************************
  // Afterrun timers
  // ****************************************
  hdsm_afterrun_if valve_if();
  hdsm_afterrun_if pump_if();

  hdsm_afterrun #(.CYC_PER_MS_P(CYC_PER_MS_P)) u_valve_tmr (
    .aclk(aclk),
    .aresetn(aresetn),
    .tmr(valve_if.timer)
  );

  hdsm_afterrun #(.CYC_PER_MS_P(CYC_PER_MS_P)) u_pump_tmr (
    .aclk(aclk),
    .aresetn(aresetn),
    .tmr(pump_if.timer)
  );

  // ****************************************
  // Output mapping
  // ****************************************
  logic hyd;
  logic [1:0] prof;
  logic [2:0] spd;
  logic up_cmd;
  logic dn_cmd;
  logic fast_spd;
  logic pump_req;
  logic pump_on;
  logic valve_req;
  logic [7:0] dir;
  logic [7:0] map;
  logic next_up;
  logic next_down;
  logic next_fast;
  logic next_aux;
  logic next_slow_up;
  logic [7:0] next_drive_ctrl;

  assign hyd = ctrl[CTRL_HYD_BIT];
  assign prof = ctrl[CTRL_PROF_LSB +: 2];
  assign spd = cmd[CMD_SPEED_LSB +: 3];
  // Both directions at once is treated as no travel
  assign up_cmd = cmd[CMD_UP_BIT] && !cmd[CMD_DOWN_BIT];
  assign dn_cmd = cmd[CMD_DOWN_BIT] && !cmd[CMD_UP_BIT];
  assign valve_hold = valve_if.hold;
  assign pump_hold = pump_if.hold;
  assign valve_if.delay_ms = valve_ar;
  assign pump_if.delay_ms = pump_ar;
  assign valve_if.demand = valve_req;
  assign pump_if.demand = pump_req;

  always_comb begin
    allowed = (!ctrl[CTRL_RAMP_BIT] || ramp_s) // [R04]
      && (!ctrl[CTRL_READY_BIT] || ready_s); // [R05]
    fast_spd = spd == SPD_MEDIUM || spd == SPD_INTERMEDIATE
      || spd == SPD_RATED;
    // Pump runs only upward; enable feedback gates it when used
    pump_req = hyd && up_cmd
      && (!ctrl[CTRL_PEN_BIT] || pen_s); // [R16]
    pump_on = pump_req || pump_hold; // [R08]
    valve_req = hyd && ctrl[CTRL_SIMPLE_BIT] && up_cmd && allowed; // [R07]
    dir = up_cmd ? DC_OUT7 : (dn_cmd ? DC_OUT8 : 8'h00);
    map = dir;
    case (prof)
      PROF_FIRST: begin
        if (spd != SPD_CREEP && spd != SPD_RELEVEL) begin
          map = dir | (up_cmd ? DC_OUT5 : DC_OUT6); // [R10]
        end
        case (spd) // [R11]
          SPD_SLOW: map = map | DC_OUT1;
          SPD_MEDIUM: map = map | DC_OUT2;
          SPD_INTERMEDIATE: map = map | DC_OUT3;
          SPD_INSPECTION, SPD_EMERGENCY: map = map | DC_OUT4;
          default: map = map;
        endcase
      end
      PROF_SECOND: begin
        case (spd)
          SPD_SLOW: map = dir | DC_OUT3; // [R13]
          SPD_MEDIUM: map = dir | (up_cmd ? DC_OUT5 : DC_OUT6); // [R14]
          SPD_INSPECTION, SPD_EMERGENCY: map = dir | DC_OUT4; // [R14]
          default: map = dir;
        endcase
      end
      PROF_THIRD: begin
        case (spd)
          SPD_SLOW, SPD_INSPECTION, SPD_EMERGENCY:
            map = dir | DC_OUT3; // [R17]
          default: map = dir;
        endcase
      end
      default: map = 8'h00; // [R18]
    endcase
    if (!dir[6] && !dir[7]) begin
      map = 8'h00;
    end
    if (hyd) begin
      next_up = pump_on; // [R02]
      next_down = dn_cmd;
      next_fast = (up_cmd || dn_cmd) && fast_spd;
      case (ctrl[CTRL_AUX_LSB +: 2])
        AUX_STAR_DELTA: next_aux = pump_on && ramp_s; // [R03]
        AUX_INVERTER: next_aux = up_cmd || dn_cmd;
        default: next_aux = pump_on;
      endcase
      next_slow_up = valve_req || valve_hold; // [R07]
      next_drive_ctrl = allowed ? map : 8'h00; // [R04]
    end else begin
      next_up = up_cmd; // [R01]
      next_down = dn_cmd;
      next_fast = (up_cmd || dn_cmd) && fast_spd;
      next_aux = (up_cmd || dn_cmd) && !fast_spd;
      next_slow_up = 1'b0;
      next_drive_ctrl = 8'h00; // [R01]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_contactor <= 1'b0;
      down_contactor <= 1'b0;
      fast_contactor <= 1'b0;
      pump_aux_contactor <= 1'b0;
      slow_up_valve <= 1'b0;
      drive_ctrl <= 8'h00;
    end else begin
      up_contactor <= next_up;
      down_contactor <= next_down;
      fast_contactor <= next_fast;
      pump_aux_contactor <= next_aux;
      slow_up_valve <= next_slow_up;
      drive_ctrl <= next_drive_ctrl;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_pole_quiet;
    @(posedge aclk) disable iff (!aresetn)
      !hyd |=> drive_ctrl == 8'h00 && !slow_up_valve;
  endproperty
  a_pole_quiet: assert property (p_pole_quiet) // [R01]
    else $error("pole motor drove a control output");

  property p_hyd_down;
    @(posedge aclk) disable iff (!aresetn)
      hyd && dn_cmd |=> down_contactor && !fast_contactor == !$past(fast_spd);
  endproperty
  a_hyd_down: assert property (p_hyd_down) // [R02]
    else $error("down or fast contactor wrong");

  property p_star_delta;
    @(posedge aclk) disable iff (!aresetn)
      hyd && ctrl[CTRL_AUX_LSB +: 2] == AUX_STAR_DELTA
      |=> pump_aux_contactor == ($past(pump_on) && $past(ramp_s));
  endproperty
  a_star_delta: assert property (p_star_delta) // [R03]
    else $error("delta switch not tied to pump and ramp");

  property p_ramp_gate;
    @(posedge aclk) disable iff (!aresetn)
      ctrl[CTRL_RAMP_BIT] && !ramp_s |=> drive_ctrl == 8'h00;
  endproperty
  a_ramp_gate: assert property (p_ramp_gate) // [R04]
    else $error("valve driven before ramp-up");

  property p_ready_ignored;
    @(posedge aclk) disable iff (!aresetn)
      hyd && !ctrl[CTRL_READY_BIT] && !ctrl[CTRL_RAMP_BIT]
      && prof == PROF_FIRST && up_cmd && spd == SPD_CREEP
      |=> drive_ctrl == DC_OUT7;
  endproperty
  a_ready_ignored: assert property (p_ready_ignored) // [R05]
    else $error("readiness input acted while unused");

  property p_no_pump_down;
    @(posedge aclk) disable iff (!aresetn)
      hyd && dn_cmd && !pump_hold |=> !up_contactor;
  endproperty
  a_no_pump_down: assert property (p_no_pump_down) // [R08]
    else $error("pump ran for downward travel");

  property p_first_rated;
    @(posedge aclk) disable iff (!aresetn)
      hyd && allowed && prof == PROF_FIRST && dn_cmd && spd == SPD_RATED
      |=> drive_ctrl == (DC_OUT8 | DC_OUT6);
  endproperty
  a_first_rated: assert property (p_first_rated) // [R11]
    else $error("rated speed mapping wrong");

  property p_second_slow;
    @(posedge aclk) disable iff (!aresetn)
      hyd && allowed && prof == PROF_SECOND && dn_cmd && spd == SPD_SLOW
      |=> drive_ctrl == (DC_OUT8 | DC_OUT3);
  endproperty
  a_second_slow: assert property (p_second_slow) // [R13]
    else $error("second profile slow mapping wrong");

  property p_third_insp;
    @(posedge aclk) disable iff (!aresetn)
      hyd && allowed && prof == PROF_THIRD && up_cmd
      && spd == SPD_INSPECTION |=> drive_ctrl == (DC_OUT7 | DC_OUT3);
  endproperty
  a_third_insp: assert property (p_third_insp) // [R17]
    else $error("third profile inspection mapping wrong");

  property p_no_profile;
    @(posedge aclk) disable iff (!aresetn)
      prof == PROF_NONE |=> drive_ctrl == 8'h00;
  endproperty
  a_no_profile: assert property (p_no_profile) // [R18]
    else $error("outputs driven with no profile");
endmodule

// >>> hdsm_valve_card.sv
// Valve card, drive and soft starter model at the mapper's far side
`timescale 1ns/1ps
module hdsm_valve_card #(
  parameter int RAMP_CYC = 20
)
(
  // Clock and pump state
  input wire logic aclk,
  input wire logic pump_run,
  // Bench knobs
  input wire logic drive_ok,
  input wire logic card_ok,
  input wire logic safety_ok,
  input wire logic pump_ok,
  // Pins to the mapper
  output logic ramp_done,
  output logic drive_ready,
  output logic safety_valve_feedback,
  output logic valve_ready_feedback,
  output logic pump_enable_request
);
  // ****
  // Soft starter: current ramps only while the pump runs
  // ****
  int cnt = 0;
  always @(posedge aclk) begin
    cnt <= pump_run ? cnt + 1 : 0;
  end
  assign ramp_done = (cnt >= RAMP_CYC);
  assign drive_ready = drive_ok;
  // Own knob so a swap with the ready feedback shows up
  assign safety_valve_feedback = safety_ok;
  assign valve_ready_feedback = card_ok;
  assign pump_enable_request = pump_ok;
endmodule

// >>> tb_hydraulic_drive_signal_mapper.sv
// Self-checking bench for the hydraulic drive signal mapper
`timescale 1ns/1ps
module tb_hydraulic_drive_signal_mapper
  import hdsm_pkg::*;
;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rd;
  logic drive_ok = 1'h1, card_ok = 1'h1, pump_ok = 1'h1;
  logic safety_ok = 1'h1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic ramp_done, drive_ready, safety_valve_feedback;
  logic valve_ready_feedback, pump_enable_request;
  logic up_contactor, down_contactor, fast_contactor;
  logic pump_aux_contactor, slow_up_valve;
  logic [7:0] drive_ctrl;
  int errors = 0, check_count = 0;

  hdsm_mapper #(.CYC_PER_MS_P(4)) hdsm_mapper_inst (.aclk, .aresetn,
    .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
    .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .ramp_done,
    .drive_ready, .safety_valve_feedback, .valve_ready_feedback,
    .pump_enable_request, .up_contactor, .down_contactor, .fast_contactor,
    .pump_aux_contactor, .slow_up_valve, .drive_ctrl);
  hdsm_valve_card #(.RAMP_CYC(20)) hdsm_valve_card_inst (.aclk,
    .pump_run(up_contactor), .drive_ok, .card_ok, .pump_ok, .safety_ok,
    .ramp_done, .drive_ready, .safety_valve_feedback, .valve_ready_feedback,
    .pump_enable_request);

  initial begin
    forever #12.5 aclk = ~aclk;
  end

  // ****
  // Bus and compare helpers
  // ****
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r = RESP_OKAY);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 50);
    bready <= 1'h0;
    chk("bvalid", 1, bvalid);
    chk("bresp", r, bresp);
  endtask

  task automatic rdr(input logic [7:0] a, input logic [1:0] r = RESP_OKAY);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 50);
    rready <= 1'h0;
    rd = rdata;
    chk("rvalid", 1, rvalid);
    chk("rresp", r, rresp);
  endtask

  // Contactor vector is {aux, fast, down, up}
  task automatic out(input logic [7:0] dc, input logic [3:0] k);
    chk("drive_ctrl", dc, drive_ctrl);
    chk("contactors", k, {pump_aux_contactor, fast_contactor,
      down_contactor, up_contactor});
  endtask

  function automatic logic [7:0] exp_dc(input logic [1:0] p,
    input logic u, input logic [2:0] s);
    logic [7:0] d, m;
    d = u ? DC_OUT7 : DC_OUT8;
    m = d | (u ? DC_OUT5 : DC_OUT6);
    case (p)
      PROF_FIRST: case (s)
        SPD_CREEP, SPD_RELEVEL: return d;
        SPD_SLOW: return m | DC_OUT1;
        SPD_MEDIUM: return m | DC_OUT2;
        SPD_INTERMEDIATE: return m | DC_OUT3;
        SPD_RATED: return m;
        default: return m | DC_OUT4;
      endcase
      PROF_SECOND: case (s)
        SPD_SLOW: return d | DC_OUT3;
        SPD_MEDIUM: return m;
        SPD_INSPECTION, SPD_EMERGENCY: return d | DC_OUT4;
        default: return d;
      endcase
      default: return (s inside {SPD_SLOW, SPD_INSPECTION, SPD_EMERGENCY})
        ? (d | DC_OUT3) : d;
    endcase
  endfunction

  // ****
  // Scenarios
  // ****
  task automatic t_regs;
    rdr(VALVE_AR_ADDR);
    chk("valve_ar", 0, rd);
    rdr(PUMP_AR_ADDR);
    chk("pump_ar", 0, rd);
    rdr(8'h14, RESP_SLVERR);
    wr(STATUS_ADDR, 32'h0000ffff);
    rdr(STATUS_ADDR);
    chk("status_out", 0, rd[23:8]);
  endtask

  task automatic t_pole;
    wr(CTRL_ADDR, 32'h0);
    wr(CMD_ADDR, 32'h41);
    cyc(4);
    out(8'h00, 4'h5);
    wr(CMD_ADDR, 32'h12);
    cyc(4);
    out(8'h00, 4'ha);
  endtask

  task automatic t_map;
    logic f;
    logic [7:0] e;
    logic [3:0] k;
    for (int p = 1; p < 4; p++) begin
      wr(CTRL_ADDR, {29'h0, p[1:0], 1'h1});
      for (int u = 0; u < 2; u++) begin
        for (int s = 0; s < 8; s++) begin
          wr(CMD_ADDR, {25'h0, s[2:0], 2'h0, ~u[0], u[0]});
          cyc(4);
          f = s inside {[2:4]};
          e = exp_dc(p[1:0], u[0], s[2:0]);
          k = {u[0], f, ~u[0], u[0]};
          out(e, k);
        end
      end
    end
    wr(CMD_ADDR, 32'h0);
    cyc(4);
    out(8'h00, 4'h0);
  endtask

  task automatic t_ramp;
    wr(CTRL_ADDR, 32'h2b);
    wr(CMD_ADDR, 32'h11);
    cyc(4);
    out(8'h00, 4'h1);
    cyc(24);
    out(8'h51, 4'h9);
    wr(CMD_ADDR, 32'h0);
    cyc(4);
    out(8'h00, 4'h0);
  endtask

  task automatic t_ready;
    drive_ok <= 1'h0;
    wr(CTRL_ADDR, 32'h43);
    wr(CMD_ADDR, 32'h01);
    cyc(6);
    chk("drive_ctrl", 8'h00, drive_ctrl);
    wr(CTRL_ADDR, 32'h03);
    cyc(4);
    chk("drive_ctrl", 8'h40, drive_ctrl);
    drive_ok <= 1'h1;
    wr(CTRL_ADDR, 32'h43);
    cyc(6);
    chk("drive_ctrl", 8'h40, drive_ctrl);
  endtask

  task automatic t_stat;
    cyc(6);
    rdr(STATUS_ADDR);
    chk("pins", 4'hf, rd[4:1]);
    card_ok <= 1'h0;
    pump_ok <= 1'h0;
    drive_ok <= 1'h0;
    cyc(6);
    rdr(STATUS_ADDR);
    chk("pins", 4'h2, rd[4:1]);
    drive_ok <= 1'h1;
  endtask

  task automatic t_pen;
    wr(CTRL_ADDR, 32'h83);
    cyc(6);
    chk("up", 0, up_contactor);
    wr(CTRL_ADDR, 32'h03);
    cyc(4);
    chk("up", 1, up_contactor);
    wr(CMD_ADDR, 32'h0);
  endtask

  task automatic t_after;
    wr(CTRL_ADDR, 32'h103);
    wr(VALVE_AR_ADDR, 32'h3);
    wr(PUMP_AR_ADDR, 32'h5);
    rdr(VALVE_AR_ADDR);
    chk("valve_ar", 3, rd);
    wr(CMD_ADDR, 32'h01);
    cyc(6);
    chk("slow_up", 1, slow_up_valve);
    wr(CMD_ADDR, 32'h0);
    cyc(4);
    chk("slow_up", 1, slow_up_valve);
    chk("up", 1, up_contactor);
    cyc(26);
    chk("slow_up", 0, slow_up_valve);
    chk("up", 0, up_contactor);
    wr(CMD_ADDR, 32'h02);
    cyc(6);
    wr(CMD_ADDR, 32'h0);
    cyc(2);
    chk("up", 0, up_contactor);
  endtask

  task automatic wrap_up;
    $display("Checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #125000;
    errors++;
    wrap_up;
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs;
    t_pole;
    t_map;
    t_ramp;
    t_ready;
    t_stat;
    t_pen;
    t_after;
    wrap_up;
  end
endmodule
